// File: rtl/hcel_loader.sv
// hub configuration loader: eeprom auto-load, hub config registers, port numbering
`timescale 1ns/1ps
// Overview of operation
// - bit 3 of port config picks remap
// - standard mode shifts enabled ports down contiguously
// - disable mask from 2Ah self, 2Bh bus
// - remap mode uses bytes 36h and 37h
// - upstream boost in bits 1:0, default zero
// - downstream boost fields ports 4,3,2
// - boost code 0..3 adds 0/4/8/12 percent
// - soft reset restores pin-reset register defaults
// - soft reset bit self-clears during reset
// - attach zero holds configuration, no upstream presence
// - attach one signals attach, write-protects 00h-FEh
// - attach resets one, write once, pin reset sets and re-arms
// - read byte 0, load only if A5h
// - bad signature uses defaults, mac all ones
// - usb, power-on, pin, ethernet resets start load
// - power-on or pin reset reloads everything
// - usb reset reloads only the mac
// - ethernet reset or reload loads ethernet part
// - port numbering byte comes from 28h
module hcel_loader
    import hcel_pkg::*;
#(
    parameter int NumPorts = 4
) (
    input wire logic sys_clk, // 10 mhz system clock
    input wire logic rst_n, // power-on reset, async low
    input wire logic clkEn, // freezes all state when low
    input wire logic extResetPulse, // external reset pin seen, one cycle
    input wire logic usbResetPulse, // usb bus reset, one cycle
    input wire logic ethSoftResetPulse, // ethernet soft reset, one cycle
    input wire logic selfPowered, // 1 = self-powered operation
    input wire logic [3:0] regAddr, // register word index
    input wire logic [7:0] regWdata, // register write data
    input wire logic regWr, // register write strobe
    input wire logic regRd, // register read strobe
    output logic [7:0] regRdata, // read data, cycle after strobe
    output hcel_eereq_s eeReq, // eeprom byte read request
    input wire logic eeAck, // eeprom data valid, one cycle
    input wire logic [7:0] eeData, // eeprom read byte
    output hcel_eth_s ethCfg, // ethernet settings
    output logic [1:0] upBoost, // upstream boost code
    output logic [7:0] dnBoost, // ports 4..2 boost codes in 7:2
    output logic [7:0] portLogical, // logical number per port, 2 bits each
    output logic [3:0] portEnable, // physical port enables
    output logic usbAttach, // present on upstream bus
    output logic loadBusy // loader running
);
    hcel_state_e state_r, state_nxt;
    hcel_scope_e scope_r;
    logic [7:0] addr_r;
    logic [7:0] portNum_r, upstream_drive_boost_r, boostDn_r, disSelf_r, disBus_r, remap12_r, remap34_r;
    logic attach_r, attachWritten_r, sigOk_r, loadBusy_r, reqOut_r, usbAtt_r;
    hcel_eth_s eth_r;
    logic [7:0] rdata_r, portLog_r;
    logic [3:0] portEn_r;

    // reset and load triggers
    wire hwReset = extResetPulse; // pin reset clears the hub bytes and sets attach again
    wire softRst = regWr && regAddr == RegStatCmd && regWdata[SoftRstBit];
    wire startAll = extResetPulse;
    wire startEth = ethSoftResetPulse || (regWr && regAddr == RegLoadCtl && regWdata[0]);
    wire startMac = usbResetPulse;
    wire anyStart = startAll || startEth || startMac;

    // writes to the config space are blocked once attached
    wire wrProt = attach_r && ({4'h0, regAddr} <= WpLast);
    wire cfgWr = regWr && !wrProt && !softRst;
    wire attachWr = regWr && regAddr == RegStatCmd && !attachWritten_r;

    // loader sequencing: signature first, then walk the map
    wire sigGood = eeData == EeSigVal;
    wire lastAddr = (scope_r == ScopeMac) ? (addr_r == EeMacHi) :
                    (scope_r == ScopeEth) ? (addr_r == EeMaxPwr) : (addr_r == EeLast);
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            LdIdle: if (anyStart) state_nxt = LdSig;
            LdSig: if (eeAck) state_nxt = sigGood ? LdRead : LdIdle;
            LdRead: state_nxt = LdWait;
            LdWait: if (eeAck) state_nxt = lastAddr ? LdIdle : LdRead;
            default: state_nxt = LdIdle;
        endcase
    end

    // loader state, scope and address
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= LdSig; // power-on starts a full load
            scope_r <= ScopeAll;
            addr_r <= EeSig;
            reqOut_r <= 1'b1;
        end
        else if (clkEn)
        begin
            state_r <= state_nxt;
            if (state_r == LdIdle && anyStart)
            begin
                scope_r <= startAll ? ScopeAll : (startEth ? ScopeEth : ScopeMac);
                addr_r <= EeSig;
            end
            else if (state_r == LdSig && eeAck)
                addr_r <= EeMacLo;
            else if (state_r == LdWait && eeAck)
                addr_r <= addr_r + 8'h01;
            // request held until answered, since the eeprom may take any number of cycles
            reqOut_r <= state_nxt != LdIdle;
        end
    end

    // ethernet settings: defaults, or bytes from the eeprom
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eth_r <= '{DefMac, DefFsPoll, DefHsPoll, DefFlags, DefMaxPwr};
            sigOk_r <= 1'b0;
        end
        else if (clkEn)
        begin
            if (state_r == LdSig && eeAck)
            begin
                sigOk_r <= sigGood;
                if (!sigGood && scope_r != ScopeMac)
                    eth_r <= '{DefMac, DefFsPoll, DefHsPoll, DefFlags, DefMaxPwr};
                else if (!sigGood)
                    eth_r.mac <= DefMac;
            end
            else if (state_r == LdWait && eeAck)
            begin
                if (addr_r >= EeMacLo && addr_r <= EeMacHi)
                    eth_r.mac <= {eth_r.mac[39:0], eeData};
                else if (addr_r == EeFsPoll)
                    eth_r.fsPoll <= eeData;
                else if (addr_r == EeHsPoll)
                    eth_r.hsPoll <= eeData;
                else if (addr_r == EeFlags)
                    eth_r.flags <= eeData;
                else if (addr_r == EeMaxPwr)
                    eth_r.maxPwr <= eeData;
            end
        end
    end

    // hub config bytes, cleared by pin and soft reset, loaded only on full loads
    wire hubLd = state_r == LdWait && eeAck && scope_r == ScopeAll;
    wire hubDef = hwReset || softRst;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            portNum_r <= DefZero;
            upstream_drive_boost_r <= DefZero;
            boostDn_r <= DefZero;
            disSelf_r <= DefZero;
            disBus_r <= DefZero;
            remap12_r <= DefZero;
            remap34_r <= DefZero;
        end
        else if (clkEn)
        begin
            if (hubDef)
            begin
                portNum_r <= DefZero;
                upstream_drive_boost_r <= DefZero;
                boostDn_r <= DefZero;
                disSelf_r <= DefZero;
                disBus_r <= DefZero;
                remap12_r <= DefZero;
                remap34_r <= DefZero;
            end
            else if (hubLd)
            begin
                if (addr_r == EePortNum) portNum_r <= eeData & PortNumMask;
                if (addr_r == EeDisSelf) disSelf_r <= eeData;
                if (addr_r == EeDisBus) disBus_r <= eeData;
                if (addr_r == EeRemap12) remap12_r <= eeData;
                if (addr_r == EeRemap34) remap34_r <= eeData;
                if (addr_r == EeBoostUp) upstream_drive_boost_r <= eeData & BoostUpMask;
                if (addr_r == EeBoostDn) boostDn_r <= eeData & BoostDnMask;
            end
            else if (cfgWr)
            begin
                if (regAddr == RegPortNum) portNum_r <= regWdata & PortNumMask;
                if (regAddr == RegBoostUp) upstream_drive_boost_r <= regWdata & BoostUpMask;
                if (regAddr == RegBoostDn) boostDn_r <= regWdata & BoostDnMask;
                if (regAddr == RegMask12) remap12_r <= regWdata;
                if (regAddr == RegMask34) remap34_r <= regWdata;
            end
        end
    end

    // attach bit: set at reset, one write allowed, only pin reset re-arms it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            attach_r <= 1'b1;
            attachWritten_r <= 1'b0;
        end
        else if (clkEn)
        begin
            if (hwReset)
            begin
                attach_r <= 1'b1;
                attachWritten_r <= 1'b0;
            end
            else if (attachWr)
            begin
                attach_r <= regWdata[AttachBit];
                attachWritten_r <= 1'b1;
            end
        end
    end

    // port numbering: standard shifts enabled ports down, remap uses nibbles
    wire remapMode = portNum_r[RemapBit];
    wire [7:0] disMask = selfPowered ? disSelf_r : disBus_r;
    logic [7:0] stdLog;
    logic [3:0] stdEn;
    always_comb
    begin
        logic [1:0] next;
        next = 2'h0;
        stdLog = 8'h00;
        stdEn = 4'h0;
        for (int p = 0; p < NumPorts; p++)
        begin
            if (!disMask[p + 1])
            begin
                stdLog[2 * p +: 2] = next;
                stdEn[p] = 1'b1;
                next = next + 2'h1;
            end
        end
    end
    wire [7:0] remapLog = {remap34_r[5:4], remap34_r[1:0], remap12_r[5:4], remap12_r[1:0]};

    // register read mux; reserved bits come back zero
    wire [7:0] stsByte = {6'h00, 1'b0, attach_r};
    wire [7:0] rdMux = (regAddr == RegPortNum) ? portNum_r :
                       (regAddr == RegBoostUp) ? upstream_drive_boost_r :
                       (regAddr == RegBoostDn) ? boostDn_r :
                       (regAddr == RegStatCmd) ? stsByte :
                       (regAddr == RegLoadSts) ? {6'h00, sigOk_r, loadBusy_r} :
                       (regAddr == RegMask12) ? remap12_r :
                       (regAddr == RegMask34) ? remap34_r : DefZero;

    // output flops; attach gated so host sees nothing in configuration state
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= DefZero;
            portLog_r <= DefZero;
            portEn_r <= 4'h0;
            loadBusy_r <= 1'b1;
            usbAtt_r <= 1'b0;
        end
        else if (clkEn)
        begin
            rdata_r <= regRd ? rdMux : DefZero;
            portLog_r <= remapMode ? remapLog : stdLog;
            portEn_r <= remapMode ? 4'hf : stdEn;
            loadBusy_r <= state_nxt != LdIdle;
            usbAtt_r <= attach_r && state_nxt == LdIdle;
        end
    end

    assign regRdata = rdata_r;
    assign eeReq = '{reqOut_r, addr_r};
    assign ethCfg = eth_r;
    assign upBoost = upstream_drive_boost_r[1:0];
    assign dnBoost = boostDn_r;
    assign portLogical = portLog_r;
    assign portEnable = portEn_r;
    assign usbAttach = usbAtt_r;
    assign loadBusy = loadBusy_r;

    AST_SIG_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && state_r == LdSig && eeAck && !sigGood) |=> state_r == LdIdle)
        else $error("bad signature did not skip load");
    AST_DEF_MAC: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && state_r == LdSig && eeAck && !sigGood) |=> eth_r.mac == DefMac)
        else $error("mac not all ones after bad signature");
    AST_PROT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && regWr && attach_r && regAddr == RegBoostUp && !hubLd && !hubDef)
        |=> $stable(upstream_drive_boost_r))
        else $error("protected write changed boost");
    AST_ONCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (attachWritten_r && !extResetPulse) |=> $stable(attach_r))
        else $error("attach written twice");
    AST_SOFT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && softRst) |=> boostDn_r == DefZero && portNum_r == DefZero)
        else $error("soft reset left config");
    AST_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (upstream_drive_boost_r & ~BoostUpMask) == 8'h00 && (portNum_r & ~PortNumMask) == 8'h00)
        else $error("reserved bits set");
    AST_ATT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && !attach_r) |=> !usbAttach)
        else $error("attached in configuration state");
    AST_MAC_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (scope_r == ScopeMac && state_r != LdIdle) |=> $stable(eth_r.flags))
        else $error("usb reset touched flags");

    // load steps: a good signature answer, and the answer to the last byte of the scope
    sequence sigPass;
        clkEn && state_r == LdSig && eeAck && sigGood;
    endsequence
    sequence ldLastAck;
        clkEn && state_r == LdWait && eeAck && lastAddr;
    endsequence
    sequence ldGone;
        !eeReq.req && !loadBusy;
    endsequence
    AST_SIG_GO: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sigPass |=> state_r == LdRead && eeReq.addr == EeMacLo)
        else $error("good signature did not start the byte walk");
    AST_LOAD_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ldLastAck |=> ldGone)
        else $error("load did not end after the last byte");
    // a dropped request would leave the walk waiting forever
    AST_REQ_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && state_r == LdWait && !eeAck) |=> eeReq.req && $stable(eeReq.addr))
        else $error("eeprom request dropped before its answer");
    AST_PIN_ATTACH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && extResetPulse) |=> attach_r)
        else $error("pin reset did not set attach");
    // ethernet-only loads must leave the hub bytes alone
    AST_ETH_HUB: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && scope_r != ScopeAll && state_r == LdWait && eeAck && !hubDef && !cfgWr)
        |=> $stable(upstream_drive_boost_r))
        else $error("ethernet load changed hub settings");
    AST_STD_DIS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clkEn && !remapMode && disMask[1]) |=> !portEnable[0])
        else $error("disabled port still enabled");
endmodule : hcel_loader

// File: pkg/hcel_pkg.sv
// package: constants, types and address map for the hub config loader
package hcel_pkg;
    // register word indices on the plain register port
    localparam logic [3:0] RegPortNum = 4'h0;
    localparam logic [3:0] RegBoostUp = 4'h1;
    localparam logic [3:0] RegBoostDn = 4'h2;
    localparam logic [3:0] RegStatCmd = 4'h3;
    localparam logic [3:0] RegLoadCtl = 4'h4;
    localparam logic [3:0] RegLoadSts = 4'h5;
    localparam logic [3:0] RegMask12 = 4'h6;
    localparam logic [3:0] RegMask34 = 4'h7;
    // eeprom byte addresses
    localparam logic [7:0] EeSig = 8'h00;
    localparam logic [7:0] EeMacLo = 8'h01;
    localparam logic [7:0] EeMacHi = 8'h06;
    localparam logic [7:0] EeFsPoll = 8'h07;
    localparam logic [7:0] EeHsPoll = 8'h08;
    localparam logic [7:0] EeFlags = 8'h09;
    localparam logic [7:0] EeMaxPwr = 8'h0a;
    localparam logic [7:0] EePortNum = 8'h28;
    localparam logic [7:0] EeDisSelf = 8'h2a;
    localparam logic [7:0] EeDisBus = 8'h2b;
    localparam logic [7:0] EeRemap12 = 8'h36;
    localparam logic [7:0] EeRemap34 = 8'h37;
    localparam logic [7:0] EeBoostUp = 8'h38;
    localparam logic [7:0] EeBoostDn = 8'h39;
    localparam logic [7:0] EeLast = 8'h39;
    localparam logic [7:0] EeSigVal = 8'ha5;
    localparam logic [7:0] WpLast = 8'hfe;
    // field layout and masks
    localparam int RemapBit = 3;
    localparam int SoftRstBit = 1;
    localparam int AttachBit = 0;
    localparam logic [7:0] PortNumMask = 8'h08;
    localparam logic [7:0] BoostUpMask = 8'h03;
    localparam logic [7:0] BoostDnMask = 8'hfc;
    // hardware defaults
    localparam logic [47:0] DefMac = 48'hffff_ffff_ffff;
    localparam logic [7:0] DefFsPoll = 8'h01;
    localparam logic [7:0] DefHsPoll = 8'h04;
    localparam logic [7:0] DefFlags = 8'h05;
    localparam logic [7:0] DefMaxPwr = 8'h01;
    localparam logic [7:0] DefZero = 8'h00;
    localparam logic [1:0] BoostNorm = 2'h0;
    localparam logic [1:0] Boost4 = 2'h1;
    localparam logic [1:0] Boost8 = 2'h2;
    localparam logic [1:0] Boost12 = 2'h3;
    // loader states, one-hot
    typedef enum logic [3:0] {
        LdIdle = 4'h1,
        LdSig = 4'h2,
        LdRead = 4'h4,
        LdWait = 4'h8
    } hcel_state_e;
    // load scope
    typedef enum logic [1:0] {
        ScopeAll = 2'h0,
        ScopeEth = 2'h1,
        ScopeMac = 2'h2
    } hcel_scope_e;
    // ethernet settings bundle
    typedef struct packed {
        logic [47:0] mac;
        logic [7:0] fsPoll;
        logic [7:0] hsPoll;
        logic [7:0] flags;
        logic [7:0] maxPwr;
    } hcel_eth_s;
    // eeprom read port
    typedef struct packed {
        logic req;
        logic [7:0] addr;
    } hcel_eereq_s;
endpackage : hcel_pkg

// File: sim/hcel_ee_model.sv
// configuration eeprom model answering byte reads from the loader
`timescale 1ns/1ps
module hcel_ee_model
    import hcel_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic slowMode, // 1 = answer after a long wait
    input hcel_eereq_s eeReq, // byte read request from the loader
    output logic eeAck, // data valid, one cycle
    output logic [7:0] eeData // read byte
);
    logic [7:0] mem [0:255];
    logic [3:0] waitCnt_r;
    logic [7:0] lastData_r;
    logic [3:0] waitMin;

    // at least two quiet cycles after an answer, so a stale request is never answered twice
    assign waitMin = slowMode ? 4'h6 : 4'h2;

    // count the wait while a request is pending, then answer for one cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitCnt_r <= 4'h0;
            eeAck <= 1'b0;
            lastData_r <= 8'h00;
        end
        else if (eeReq.req && !eeAck && waitCnt_r >= waitMin)
        begin
            eeAck <= 1'b1;
            lastData_r <= mem[eeReq.addr];
            waitCnt_r <= 4'h0;
        end
        else
        begin
            eeAck <= 1'b0;
            waitCnt_r <= eeReq.req ? waitCnt_r + 4'h1 : 4'h0;
        end
    end

    // off the answer cycle the line shows the inverse of the last byte, never a stale copy
    assign eeData = eeAck ? lastData_r : ~lastData_r;
endmodule : hcel_ee_model

// File: sim/test_hub_config_eeprom_loader.sv
// self-checking bench for the hub configuration loader
`timescale 1ns/1ps
module test_hub_config_eeprom_loader;
    import hcel_pkg::*;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdExp;
        logic [1:0] upExp;
        logic [7:0] dnExp;
    } hcel_row_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic extResetPulse = 1'b0;
    logic usbResetPulse = 1'b0;
    logic ethSoftResetPulse = 1'b0;
    logic clkEn = 1'b1;
    logic selfPowered = 1'b1;
    logic slowMode = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    hcel_eereq_s eeReq;
    logic eeAck;
    logic [7:0] eeData;
    hcel_eth_s ethCfg;
    logic [1:0] upBoost;
    logic [7:0] dnBoost;
    logic [7:0] portLogical;
    logic [3:0] portEnable;
    logic usbAttach;
    logic loadBusy;
    int failures = 0;
    int comparisons = 0;
    int cycleCount = 0;
    logic [7:0] rd;
    hcel_row_s rows [0:9];

    // 10 mhz clock
    always #50 sys_clk = ~sys_clk;

    hcel_loader #(.NumPorts(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .extResetPulse(extResetPulse), .usbResetPulse(usbResetPulse),
        .ethSoftResetPulse(ethSoftResetPulse), .selfPowered(selfPowered), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .eeReq(eeReq),
        .eeAck(eeAck), .eeData(eeData), .ethCfg(ethCfg), .upBoost(upBoost), .dnBoost(dnBoost),
        .portLogical(portLogical), .portEnable(portEnable), .usbAttach(usbAttach),
        .loadBusy(loadBusy));

    hcel_ee_model eeModel (.sys_clk(sys_clk), .rst_n(rst_n), .slowMode(slowMode),
        .eeReq(eeReq), .eeAck(eeAck), .eeData(eeData));

    task print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // a hang counts as a mismatch; a full load takes a few hundred cycles at most
    always @(posedge sys_clk)
    begin
        cycleCount++;
        if (cycleCount == 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    task chkVal(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkVal

    task chkEth(input logic [47:0] mac, input logic [31:0] rest);
        chkVal(ethCfg.mac, mac);
        chkVal({ethCfg.fsPoll, ethCfg.hsPoll, ethCfg.flags, ethCfg.maxPwr}, rest);
    endtask : chkEth

    task regWrite(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : regWrite

    // read data stand in the cycle after the strobe: sample once that edge has settled
    task regRead(input logic [3:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask : regRead

    // pulse one reset source (0 pin, 1 usb, 2 ethernet) and wait for the loader to settle
    task runLoad(input int kind);
        @(posedge sys_clk);
        extResetPulse <= (kind == 0);
        usbResetPulse <= (kind == 1);
        ethSoftResetPulse <= (kind == 2);
        @(posedge sys_clk);
        extResetPulse <= 1'b0;
        usbResetPulse <= 1'b0;
        ethSoftResetPulse <= 1'b0;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 3000 && loadBusy !== 1'b0; i++)
            @(posedge sys_clk);
        @(posedge sys_clk);
    endtask : runLoad

    initial
    begin
        for (int i = 0; i < 256; i++)
            eeModel.mem[i] = 8'h00;
        {eeModel.mem[1], eeModel.mem[2], eeModel.mem[3]} = 24'h123456;
        {eeModel.mem[4], eeModel.mem[5], eeModel.mem[6]} = 24'h789abc;
        {eeModel.mem[7], eeModel.mem[8], eeModel.mem[9], eeModel.mem[10]} = 32'h02060703;
        eeModel.mem[8'h2a] = 8'h02;
        eeModel.mem[8'h36] = 8'h21;
        eeModel.mem[8'h37] = 8'h03;
        eeModel.mem[8'h38] = 8'hfe;
        eeModel.mem[8'h39] = 8'he5;
        rows[0] = {RegBoostUp, 8'hff, 8'h03, 2'h3, 8'he4};
        rows[1] = {RegBoostUp, 8'h00, 8'h00, 2'h0, 8'he4};
        rows[2] = {RegBoostUp, 8'h01, 8'h01, 2'h1, 8'he4};
        rows[3] = {RegBoostUp, 8'h02, 8'h02, 2'h2, 8'he4};
        rows[4] = {RegBoostDn, 8'hff, 8'hfc, 2'h2, 8'hfc};
        rows[5] = {RegBoostDn, 8'h1b, 8'h18, 2'h2, 8'h18};
        rows[6] = {RegBoostDn, 8'h00, 8'h00, 2'h2, 8'h00};
        rows[7] = {RegPortNum, 8'hff, 8'h08, 2'h2, 8'h00};
        rows[8] = {RegPortNum, 8'h00, 8'h00, 2'h2, 8'h00};
        rows[9] = {4'h9, 8'h5a, 8'h00, 2'h2, 8'h00}; // unmapped index reads zero
        // power-on with a blank signature: defaults only, attach set
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        runLoad(3);
        chkEth(DefMac, 32'h01040501);
        regRead(RegStatCmd);
        chkVal(rd, 8'h01);
        // programmed eeprom, pin reset, self-powered standard numbering
        eeModel.mem[0] = EeSigVal;
        runLoad(0);
        chkEth(48'h123456789abc, 32'h02060703);
        chkVal({upBoost, dnBoost}, 10'h2e4);
        chkVal({portEnable, portLogical & 8'hf3}, 12'he90);
        chkVal(usbAttach, 1'b1);
        regWrite(RegBoostUp, 8'h00);
        regRead(RegBoostUp);
        chkVal({rd, upBoost}, 10'h00a);
        // usb reset reloads the address only, ethernet reset the ethernet part only
        eeModel.mem[1] = 8'hab;
        eeModel.mem[7] = 8'h09;
        eeModel.mem[8'h38] = 8'hfd;
        runLoad(1);
        chkVal({ethCfg.mac[47:40], ethCfg.fsPoll, 6'h00, upBoost}, 24'hab0202);
        runLoad(2);
        chkVal({ethCfg.mac[47:40], ethCfg.fsPoll, 6'h00, upBoost}, 24'hab0902);
        // remap mode from byte 28h, slow eeprom, bus-powered
        eeModel.mem[EePortNum] = 8'h08;
        selfPowered <= 1'b0;
        slowMode <= 1'b1;
        runLoad(0);
        regRead(RegPortNum);
        chkVal({rd, portLogical, 6'h00, upBoost}, 24'h083901);
        // clear attach once; the second write is refused
        regWrite(RegStatCmd, 8'h00);
        repeat (2) @(posedge sys_clk);
        chkVal(usbAttach, 1'b0);
        regWrite(RegStatCmd, 8'h01);
        regRead(RegStatCmd);
        chkVal(rd, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            regWrite(rows[i].addr, rows[i].wdata);
            regRead(rows[i].addr);
            chkVal({rd, upBoost, dnBoost}, {rows[i].rdExp, rows[i].upExp, rows[i].dnExp});
        end
        // standard numbering again, bus-powered mask blank: all ports in order
        chkVal({portEnable, portLogical}, 12'hfe4);
        // with the clock enable low a write must leave no trace
        @(posedge sys_clk);
        clkEn <= 1'b0;
        regWrite(RegBoostUp, 8'h01);
        clkEn <= 1'b1;
        regRead(RegBoostUp);
        chkVal({rd, upBoost}, 10'h00a);
        // soft register reset with a blank signature so any reload gives defaults too
        eeModel.mem[0] = 8'h00;
        regWrite(RegBoostUp, 8'h03);
        regWrite(RegStatCmd, 8'h02);
        runLoad(3);
        regRead(RegStatCmd);
        chkVal(rd & 8'h02, 8'h00);
        regRead(RegBoostUp);
        chkVal({rd, upBoost}, 10'h000);
        // pin reset restores attach and, with no signature, the defaults
        runLoad(0);
        chkEth(DefMac, 32'h01040501);
        chkVal(usbAttach, 1'b1);
        print_verdict();
    end
endmodule : test_hub_config_eeprom_loader
